// ==== bench/acc_analog_src.sv ====
// Analog sources on the comparator inputs, folded into one result bit
`timescale 1ns/1ps
module acc_analog_src #(
	parameter int AVDD_MV = 3300
) (
	// Pin voltages in millivolts
	input  wire logic [15:0] pos_pin_mv,
	input  wire logic [15:0] neg_pin_mv,
	// Steering from the block
	input  wire logic        positive_from_ladder_q,
	input  wire logic        ladder_power_q,
	input  wire logic [4:0]  ref_numerator_q,
	input  wire logic [4:0]  ref_denominator_q,
	// Comparator result
	output logic             comparator_raw
);
	int ref_mv;

	// Ladder tap voltage, ground while the ladder is unpowered
	always_comb begin
		ref_mv = 0;
		if (ladder_power_q === 1'b1 && ref_denominator_q != 5'h00) begin
			ref_mv = AVDD_MV * ref_numerator_q / ref_denominator_q;
		end
	end

	// Negative side always comes from its pin
	assign comparator_raw = ((positive_from_ladder_q === 1'b1) ? ref_mv
		: int'(pos_pin_mv)) > int'(neg_pin_mv);
endmodule : acc_analog_src

// ==== bench/testbench.sv ====
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module testbench;
	import acc_pkg::*;
	logic clock = 1'b0, rst = 1'b1, ce = 1'b1, raw, inv = 1'b0;
	// Source select is set from time zero, before the comparator is used
	logic [1:0] src = 2'h0;
	acc_edge_type irq_m = ACC_EDGE_RISE, adc_m = ACC_EDGE_FALL;
	logic l_en = 1'b0, l_rng = 1'b0, irq_en = 1'b0, irq_clr = 1'b0;
	logic [3:0] tap = 4'h0;
	logic alt = 1'b0, g_out = 1'b0, g_oe = 1'b0;
	// Input pins are driven as analog levels only, no digital input path
	logic [15:0] pos_mv = 16'h03E8, neg_mv = 16'h0672;
	logic from_lad, neg_pin, pwr, val, rirq, mirq, cirq, adc, pin, pin_oe;
	logic [4:0] num, digital_input_enable;
	int mismatches = 0, cmp_count = 0, adc_cnt = 0;

	always #2.5 clock = ~clock;
	// Count trigger pulses as they are sampled
	always @(posedge clock) adc_cnt <= adc_cnt + int'(adc === 1'b1);

	acc_top u_acc_top (.clock(clock), .rst(rst), .ce(ce),
		.comparator_raw(raw), .positive_source_select(src),
		.output_invert(inv), .irq_edge_mode(irq_m), .adc_edge_mode(adc_m),
		.ladder_enable(l_en), .ladder_range_select(l_rng), .ladder_tap(tap),
		.irq_enable(irq_en), .irq_clear(irq_clr), .alt_function_select(alt),
		.gpio_out(g_out), .gpio_oe(g_oe), .positive_from_ladder_q(from_lad),
		.negative_from_pin_q(neg_pin), .ladder_power_q(pwr),
		.ref_numerator_q(num), .ref_denominator_q(digital_input_enable),
		.comparator_value_q(val), .raw_irq_status_q(rirq),
		.masked_irq_status_q(mirq), .controller_irq_q(cirq),
		.adc_trigger_q(adc), .comparator_output_pin_q(pin),
		.comparator_output_pin_oe_q(pin_oe));
	acc_analog_src u_acc_analog_src (.pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv),
		.positive_from_ladder_q(from_lad), .ladder_power_q(pwr),
		.ref_numerator_q(num), .ref_denominator_q(digital_input_enable), .comparator_raw(raw));

	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask : step

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict

	// Values held while reset is asserted
	task automatic t_reset();
		chk("pwr", 8'(pwr), 8'h00);
		chk("neg", 8'(neg_pin), 8'h01);
		chk("pin_oe", 8'(pin_oe), 8'h00);
		chk("rirq", 8'(rirq), 8'h00);
	endtask : t_reset

	// Ladder ratios at both ends of the tap range
	task automatic t_ladder();
		l_en = 1'b1;
		for (int r = 0; r < 2; r++) begin
			for (int t = 0; t < 16; t += 15) begin
				l_rng = r[0];
				tap = t[3:0];
				step(2);
				chk("num", 8'(num), 8'(r ? t : t + 8));
				chk("den", 8'(digital_input_enable), r ? 8'h17 : 8'h1F);
				chk("pwr", 8'(pwr), 8'h01);
			end
		end
		// Low enable freezes the ratio outputs
		ce = 1'b0;
		tap = 4'h5;
		step(2);
		chk("num_hold", 8'(num), 8'h0F);
		tap = 4'hF;
		ce = 1'b1;
	endtask : t_ladder

	// Every source code, ladder above and pin below the negative side
	task automatic t_source();
		for (int c = 0; c < 4; c++) begin
			src = c[1:0];
			step(5);
			chk("from_lad", 8'(from_lad), 8'(c == 2));
			chk("val", 8'(val), 8'(c == 2));
		end
		src = 2'h2;
		l_en = 1'b0;
		step(5);
		chk("val_gnd", 8'(val), 8'h00);
		chk("pwr_off", 8'(pwr), 8'h00);
		src = 2'h0;
	endtask : t_source

	task automatic pulse_clear();
		irq_clr = 1'b1;
		step(1);
		irq_clr = 1'b0;
		step(1);
	endtask : pulse_clear

	// Interrupt on rise, trigger on fall, masking and clearing
	task automatic t_edges();
		int adc_base;
		step(6);
		pulse_clear();
		adc_base = adc_cnt;
		pos_mv = 16'h07D0;
		step(2);
		chk("val_sync", 8'(val), 8'h00);
		step(1);
		chk("val", 8'(val), 8'h01);
		step(3);
		chk("rirq", 8'(rirq), 8'h01);
		chk("mirq", 8'(mirq), 8'h00);
		chk("cirq", 8'(cirq), 8'h00);
		chk("adc_rise", 8'(adc_cnt - adc_base), 8'h00);
		pos_mv = 16'h03E8;
		step(6);
		chk("adc_fall", 8'(adc_cnt - adc_base), 8'h01);
		pulse_clear();
		chk("rirq_clr", 8'(rirq), 8'h00);
		irq_en = 1'b1;
		pos_mv = 16'h07D0;
		step(6);
		chk("mirq", 8'(mirq), 8'h01);
		chk("cirq", 8'(cirq), 8'h01);
		pulse_clear();
		chk("cirq_clr", 8'(cirq), 8'h00);
	endtask : t_edges

	// Swapped, both-edge and level modes on the two paths
	task automatic t_modes();
		int adc_base;
		irq_m = ACC_EDGE_FALL;
		adc_m = ACC_EDGE_RISE;
		adc_base = adc_cnt;
		pos_mv = 16'h03E8;
		step(6);
		chk("irq_fall", 8'(rirq), 8'h01);
		chk("adc_nofall", 8'(adc_cnt - adc_base), 8'h00);
		pulse_clear();
		pos_mv = 16'h07D0;
		step(6);
		chk("irq_norise", 8'(rirq), 8'h00);
		chk("adc_up", 8'(adc_cnt - adc_base), 8'h01);
		adc_m = ACC_EDGE_BOTH;
		irq_m = ACC_EDGE_LEVEL;
		pos_mv = 16'h03E8;
		step(6);
		pos_mv = 16'h07D0;
		step(6);
		chk("adc_both", 8'(adc_cnt - adc_base), 8'h03);
		pulse_clear();
		chk("irq_level", 8'(rirq), 8'h01);
	endtask : t_modes

	// Pin is GPIO until the alternate function is chosen
	task automatic t_pin();
		g_out = 1'b1;
		g_oe = 1'b1;
		step(2);
		chk("gpio", 8'({pin, pin_oe}), 8'h03);
		g_out = 1'b0;
		g_oe = 1'b0;
		alt = 1'b1;
		step(2);
		chk("alt", 8'({pin, pin_oe}), 8'h03);
		inv = 1'b1;
		step(5);
		chk("alt_inv", 8'({pin, pin_oe}), 8'h01);
	endtask : t_pin

	// Main sequence
	initial begin
		step(11);
		t_reset();
		step(1);
		rst = 1'b0;
		t_ladder();
		t_source();
		t_edges();
		t_modes();
		// Second reset in mid-run with the raw status pending
		rst = 1'b1;
		step(1);
		t_reset();
		rst = 1'b0;
		t_pin();
		give_verdict();
	end

	// Watchdog far beyond the roughly 115 cycles the tests need
	initial begin
		#20000;
		mismatches++;
		give_verdict();
	end
endmodule : testbench

// ==== hdl/acc_edge_det.sv ====
// Edge or level event detector for one result path
`timescale 1ns/1ps
module acc_edge_det (
	// Sample pair, mode and event
	acc_edge_if.det e
);
	import acc_pkg::*;

	// Event from current and previous synchronised sample
	always_comb begin
		unique case (e.mode)
			ACC_EDGE_LEVEL: e.hit = e.cur;
			ACC_EDGE_FALL:  e.hit = e.prev & ~e.cur;
			ACC_EDGE_RISE:  e.hit = e.cur & ~e.prev;
			ACC_EDGE_BOTH:  e.hit = e.cur ^ e.prev;
		endcase
	end

endmodule : acc_edge_det

// ==== hdl/acc_edge_if.sv ====
// Carrier between the top and one edge detector
`timescale 1ns/1ps
interface acc_edge_if;
	logic                 cur;
	logic                 prev;
	acc_pkg::acc_edge_type mode;
	logic                 hit;

	modport det  (input cur, input prev, input mode, output hit);
	modport user (output cur, output prev, output mode, input hit);
endinterface : acc_edge_if

// ==== hdl/acc_pkg.sv ====
// Constants and types shared by the comparator control block
package acc_pkg;

	// Positive operand source codes
	localparam logic [1:0] ACC_SRC_PIN_A  = 2'h0;
	localparam logic [1:0] ACC_SRC_PIN_B  = 2'h1;
	localparam logic [1:0] ACC_SRC_LADDER = 2'h2;
	localparam logic [1:0] ACC_SRC_RSVD   = 2'h3;

	// Ladder arithmetic
	localparam int         ACC_TAP_W      = 4;
	localparam int         ACC_RATIO_W    = 5;
	localparam logic [4:0] ACC_TAP_OFFSET = 5'h08;
	localparam logic [4:0] ACC_DEN_LOW    = 5'h1F;
	localparam logic [4:0] ACC_DEN_HIGH   = 5'h17;

	// Reset values
	localparam logic       ACC_LADDER_RST = 1'h0;
	localparam logic [4:0] ACC_RATIO_RST  = 5'h00;
	localparam logic       ACC_FLAG_RST   = 1'h0;
	localparam logic       ACC_NEG_PIN    = 1'h1;

	// Synchroniser depth before edge detection
	localparam int         ACC_SYNC_STAGES = 2;

	// Edge selection for the interrupt and trigger paths
	typedef enum logic [1:0] {
		ACC_EDGE_LEVEL = 2'b00,
		ACC_EDGE_FALL  = 2'b01,
		ACC_EDGE_RISE  = 2'b10,
		ACC_EDGE_BOTH  = 2'b11
	} acc_edge_type;

endpackage : acc_pkg

// ==== hdl/acc_top.sv ====
// Digital control of one analog comparator
//
// Behaviour
// RQ1 - Interrupt and ADC trigger each have their own edge detector and mode.
// RQ2 - The result drives the output pin, the interrupt and the ADC trigger.
// RQ3 - The negative operand always comes from the negative input pin.
// RQ4 - Source codes 00 and 01 pick the pin, 10 the ladder, 11 is reserved.
// RQ5 - Software programs the positive source select before use.
// RQ6 - The output pin is plain GPIO until the alternate function is chosen.
// RQ7 - Software clears the digital input enable on the input pins.
// RQ8 - With the ladder disabled the reference is ground whatever the tap.
// RQ9 - Ladder on, range 0: reference ratio is (tap plus 8) over 31.
// RQ10 - Ladder on, range 1: reference ratio is tap over 23.
// RQ11 - Interrupts use masked status, raw status and an enable bit.
// RQ12 - Writing 1 to the status bit clears it; raw shows any interrupt.
// RQ13 - The interrupt reaches the controller only while enabled.
// RQ14 - The ladder enable resets to 0, leaving the reference unpowered.
// RQ15 - The result is synchronised before any edge detection.
`timescale 1ns/1ps
module acc_top (
	// Clock, reset, enable
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   ce,
	// Asynchronous comparator result
	input  wire logic                   comparator_raw,
	// Comparator control
	input  wire logic [1:0]             positive_source_select,
	input  wire logic                   output_invert,
	input  wire acc_pkg::acc_edge_type  irq_edge_mode,
	input  wire acc_pkg::acc_edge_type  adc_edge_mode,
	// Reference control
	input  wire logic                   ladder_enable,
	input  wire logic                   ladder_range_select,
	input  wire logic [3:0]             ladder_tap,
	// Interrupt control
	input  wire logic                   irq_enable,
	input  wire logic                   irq_clear,
	// Output pin muxing
	input  wire logic                   alt_function_select,
	input  wire logic                   gpio_out,
	input  wire logic                   gpio_oe,
	// Analog steering
	output logic                        positive_from_ladder_q,
	output logic                        negative_from_pin_q,
	output logic                        ladder_power_q,
	output logic [4:0]                  ref_numerator_q,
	output logic [4:0]                  ref_denominator_q,
	// Status and events
	output logic                        comparator_value_q,
	output logic                        raw_irq_status_q,
	output logic                        masked_irq_status_q,
	output logic                        controller_irq_q,
	output logic                        adc_trigger_q,
	// Output pin
	output logic                        comparator_output_pin_q,
	output logic                        comparator_output_pin_oe_q
);
	import acc_pkg::*;

	logic [ACC_SYNC_STAGES-1:0] sync_q;
	logic                       value_d;
	logic                       prev_q;
	logic                       raw_irq_d;

	acc_edge_if irq_if ();
	acc_edge_if adc_if ();

	// Two-stage synchroniser on the comparator result
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_q <= '0;
		end else if (ce) begin
			sync_q <= {sync_q[0], comparator_raw}; // RQ15
		end
	end

	// Conditioned value and its previous sample
	assign value_d = sync_q[ACC_SYNC_STAGES-1] ^ output_invert;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			comparator_value_q <= ACC_FLAG_RST;
			prev_q             <= ACC_FLAG_RST;
		end else if (ce) begin
			comparator_value_q <= value_d;
			prev_q             <= comparator_value_q;
		end
	end

	// Separate detectors for the two event paths
	assign irq_if.cur  = comparator_value_q; // RQ1
	assign irq_if.prev = prev_q;
	assign irq_if.mode = irq_edge_mode;
	assign adc_if.cur  = comparator_value_q; // RQ1
	assign adc_if.prev = prev_q;
	assign adc_if.mode = adc_edge_mode;

	acc_edge_det u_irq_det (
		.e (irq_if)
	);

	acc_edge_det u_adc_det (
		.e (adc_if)
	);

	// Raw status: a new event wins over a clear in the same cycle
	assign raw_irq_d = irq_if.hit | (raw_irq_status_q & ~irq_clear); // RQ12

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			raw_irq_status_q    <= ACC_FLAG_RST;
			masked_irq_status_q <= ACC_FLAG_RST;
			controller_irq_q    <= ACC_FLAG_RST;
		end else if (ce) begin
			raw_irq_status_q    <= raw_irq_d; // RQ11
			masked_irq_status_q <= raw_irq_d & irq_enable; // RQ11
			controller_irq_q    <= raw_irq_d & irq_enable; // RQ13
		end
	end

	// ADC trigger pulse
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			adc_trigger_q <= ACC_FLAG_RST;
		end else if (ce) begin
			adc_trigger_q <= adc_if.hit; // RQ2
		end
	end

	// Output pin: GPIO until the alternate function is selected
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			comparator_output_pin_q    <= ACC_FLAG_RST;
			comparator_output_pin_oe_q <= ACC_FLAG_RST;
		end else if (ce) begin
			if (alt_function_select) begin
				comparator_output_pin_q    <= value_d; // RQ2
				comparator_output_pin_oe_q <= 1'b1; // RQ6
			end else begin
				comparator_output_pin_q    <= gpio_out; // RQ6
				comparator_output_pin_oe_q <= gpio_oe;
			end
		end
	end

	// Operand steering
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			positive_from_ladder_q <= ACC_FLAG_RST;
			negative_from_pin_q    <= ACC_NEG_PIN;
		end else if (ce) begin
			// Reserved code keeps the pin path
			positive_from_ladder_q <= positive_source_select == ACC_SRC_LADDER; // RQ4
			negative_from_pin_q    <= ACC_NEG_PIN; // RQ3
		end
	end

	// Reference ladder ratio
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ladder_power_q    <= ACC_LADDER_RST; // RQ14
			ref_numerator_q   <= ACC_RATIO_RST;
			ref_denominator_q <= ACC_DEN_LOW;
		end else if (ce) begin
			ladder_power_q <= ladder_enable;
			if (!ladder_enable) begin
				ref_numerator_q   <= ACC_RATIO_RST; // RQ8
				ref_denominator_q <= ladder_range_select ? ACC_DEN_HIGH
				                                         : ACC_DEN_LOW;
			end else if (!ladder_range_select) begin
				ref_numerator_q   <= {1'b0, ladder_tap} + ACC_TAP_OFFSET; // RQ9
				ref_denominator_q <= ACC_DEN_LOW; // RQ9
			end else begin
				ref_numerator_q   <= {1'b0, ladder_tap}; // RQ10
				ref_denominator_q <= ACC_DEN_HIGH; // RQ10
			end
		end
	end

	// Checks
	sequence s_rise_seen;
		ce && comparator_value_q && !prev_q;
	endsequence

	sequence s_fall_seen;
		ce && !comparator_value_q && prev_q;
	endsequence

	a_irq_rise_set: assert property (@(posedge clock) disable iff (rst) // RQ1
		irq_edge_mode == ACC_EDGE_RISE ##0 s_rise_seen |=> raw_irq_status_q)
		else $error("rising edge did not set raw status");

	a_adc_fall_trig: assert property (@(posedge clock) disable iff (rst) // RQ1
		adc_edge_mode == ACC_EDGE_FALL ##0 s_fall_seen |=> adc_trigger_q)
		else $error("falling edge did not trigger ADC");

	a_adc_no_spur: assert property (@(posedge clock) disable iff (rst) // RQ2
		ce && adc_edge_mode == ACC_EDGE_RISE && !(comparator_value_q && !prev_q)
		|=> !adc_trigger_q)
		else $error("ADC trigger without rising edge");

	a_irq_clear_w1c: assert property (@(posedge clock) disable iff (rst) // RQ12
		ce && irq_clear && !irq_if.hit |=> !raw_irq_status_q)
		else $error("clear did not drop raw status");

	a_irq_mask_gate: assert property (@(posedge clock) disable iff (rst) // RQ13
		ce |=> controller_irq_q == (raw_irq_status_q && $past(irq_enable)))
		else $error("interrupt forwarded while disabled");

	a_pin_gpio_mode: assert property (@(posedge clock) disable iff (rst) // RQ6
		ce && !alt_function_select |=> comparator_output_pin_q == $past(gpio_out)
		&& comparator_output_pin_oe_q == $past(gpio_oe))
		else $error("pin not following GPIO");

	a_src_select: assert property (@(posedge clock) disable iff (rst) // RQ4
		ce |=> positive_from_ladder_q ==
		($past(positive_source_select) == ACC_SRC_LADDER))
		else $error("positive source mismatch");

	a_ladder_ground: assert property (@(posedge clock) disable iff (rst) // RQ8
		ce && !ladder_enable |=> ref_numerator_q == 5'h00 && !ladder_power_q)
		else $error("disabled ladder not at ground");

	a_ladder_low: assert property (@(posedge clock) disable iff (rst) // RQ9
		ce && ladder_enable && !ladder_range_select |=>
		ref_numerator_q == {1'b0, $past(ladder_tap)} + 5'h08
		&& ref_denominator_q == 5'h1F)
		else $error("low range ratio wrong");

	a_ladder_high: assert property (@(posedge clock) disable iff (rst) // RQ10
		ce && ladder_enable && ladder_range_select |=>
		ref_numerator_q == {1'b0, $past(ladder_tap)}
		&& ref_denominator_q == 5'h17)
		else $error("high range ratio wrong");

	a_sync_latency: assert property (@(posedge clock) disable iff (rst) // RQ15
		ce && !output_invert ##1 ce && !output_invert ##1 ce && !output_invert
		|=> comparator_value_q == $past(comparator_raw, 3))
		else $error("result synchroniser latency wrong");

endmodule : acc_top
